// ===== src/sscpc_pkg.sv
// Shared constants and types for the spread clock PLL control block
package sscpc_pkg;

  // Bus geometry: register index is byte address divided by four
  localparam int          ADDR_W = 8;
  localparam int          DATA_W = 32;
  localparam int          IDX_W  = 6;
  localparam int          IDX_LSB = 2;
  localparam int          REG_W  = 8;
  localparam int          HOLD_W = 7;
  localparam int          PAGE_W = 4;
  localparam int          MULT_W = 9;

  // Register indices
  localparam logic [IDX_W-1:0] IDX_SPREAD_CTRL2 = 6'h1b;
  localparam logic [IDX_W-1:0] IDX_MULT_M       = 6'h1c;
  localparam logic [IDX_W-1:0] IDX_DIV_N        = 6'h1d;
  localparam logic [IDX_W-1:0] IDX_FIFO_HOLD    = 6'h1e;
  localparam logic [IDX_W-1:0] IDX_PAGE         = 6'h1f;
  localparam logic [IDX_W-1:0] IDX_STATUS       = 6'h20;

  // Page that holds the clock control registers
  localparam logic [PAGE_W-1:0] PAGE_SPREAD = 4'h2;
  localparam logic [PAGE_W-1:0] PAGE_RESET  = 4'h0;

  // Reset values
  localparam logic [REG_W-1:0] CTRL2_RESET = 8'h02;
  localparam logic [REG_W-1:0] MULT_RESET  = 8'h00;
  localparam logic [REG_W-1:0] DIV_RESET   = 8'h00;
  localparam logic [HOLD_W-1:0] HOLD_RESET = 7'h00;

  // Field positions in spread_control_two
  localparam int C2_LOAD_SM   = 7;
  localparam int C2_FIFO_LS   = 6;
  localparam int C2_WAVE_LS   = 5;
  localparam int C2_OVR_SECOND_MULTIPLIER_LOOP  = 4;
  localparam int C2_OVR_FIRST_MULTIPLIER_LOOP  = 3;
  localparam int C2_MAX_RATE  = 2;
  localparam int C2_MODE_HI   = 1;
  localparam int C2_MODE_LO   = 0;

  // Field positions in fifo_reset_and_holdoff
  localparam int FH_FIFO_RST  = 7;
  localparam int FH_HOLD_HI   = 6;

  // Field positions in the status register
  localparam int ST_FIRST_MULTIPLIER_LOOP_LOCK = 0;
  localparam int ST_SECOND_MULTIPLIER_LOOP_LOCK = 1;
  localparam int ST_HOLD_BUSY = 2;
  localparam int ST_SPREAD_ON = 3;

  // Bit positions of the synchronised pins
  localparam int PIN_LINE = 0;
  localparam int PIN_DET1 = 1;
  localparam int PIN_DET2 = 2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // PLL mode codes
  typedef enum logic [1:0] {
    MODE_OUT_MULT   = 2'b00,
    MODE_ALL_MULT   = 2'b01,
    MODE_OFF        = 2'b10,
    MODE_ALL_NOMULT = 2'b11
  } sscpc_mode_t;

endpackage

// ===== src/sscpc_hold_if.sv
// Holdoff request and completion signals between control and counter
interface sscpc_hold_if;
  import sscpc_pkg::*;
  logic              trig;
  logic [HOLD_W-1:0] count;
  logic              fire;
  logic              busy;
  modport ctrl (output trig, output count, input fire, input busy);
  modport cnt  (input trig, input count, output fire, output busy);
endinterface

// ===== src/sscpc_sync.sv
// Two-flop synchroniser for asynchronous pin levels
module sscpc_sync #(
  parameter int W = 3
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         resetn,
  // Levels
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } sscpc_sync_t;

  sscpc_sync_t st_ff;
  sscpc_sync_t nxt_st;

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.stage1 = asyncIn;
    nxt_st.stage2 = st_ff.stage1;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign syncOut = st_ff.stage2;
endmodule

// ===== src/sscpc_holdoff.sv
// Holdoff counter that delays line-sync resets by a programmed cycle count
module sscpc_holdoff (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // Request and completion
  sscpc_hold_if.cnt hold
);
  import sscpc_pkg::*;

  typedef enum logic {
    HO_IDLE  = 1'b0,
    HO_COUNT = 1'b1
  } sscpc_ho_state_t;

  typedef struct packed {
    sscpc_ho_state_t   state;
    logic [HOLD_W-1:0] remain;
    logic              fire;
  } sscpc_ho_t;

  sscpc_ho_t st_ff;
  sscpc_ho_t nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.fire = 1'b0;
    case (st_ff.state)
      HO_IDLE: begin
        if (hold.trig && hold.count == '0) begin
          nxt_st.fire = 1'b1;
        end else if (hold.trig) begin
          nxt_st.remain = hold.count;
          nxt_st.state  = HO_COUNT;
        end
      end
      HO_COUNT: begin
        // A new line sync restarts the wait rather than stacking
        if (hold.trig && hold.count == '0) begin
          nxt_st.fire  = 1'b1;
          nxt_st.state = HO_IDLE;
        end else if (hold.trig) begin
          nxt_st.remain = hold.count;
        end else if (st_ff.remain == 7'h01) begin
          nxt_st.fire  = 1'b1;
          nxt_st.state = HO_IDLE;
        end else begin
          nxt_st.remain = st_ff.remain - 7'h01;
        end
      end
      default: begin
        nxt_st.state = HO_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '{state: HO_IDLE, remain: '0, fire: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hold.fire = st_ff.fire;
  assign hold.busy = (st_ff.state == HO_COUNT);
endmodule

// ===== src/sscpc_top.sv
// Register file and control for the spread clock PLL pair, AXI4-Lite slave
// What this block does
// - The second loop override bit forces its lock indication high.
// - The first loop override bit forces its lock indication high.
// - The max-rate bit drives modulation at its highest rate.
// - The mode field resets to the code with both loops and spreading off.
// - Mode codes 11, 01 and 00 pick the three spread configurations.
// - The divider N is the stored byte plus one, 1 to 256.
// - Writing 1 to the FIFO reset bit pulses a FIFO reset and self-clears.
// - Line-sync resets wait the programmed holdoff, 0 to 127 cycles.
// - With its enable set, each line sync not followed by another within the holdoff restarts the spread waveform.
// - FIFO resets on spread start, and on line sync when enabled.
//
// The AXI4-Lite register port was decided locally.
module sscpc_top (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          resetn,
  // AXI4-Lite write address
  input  wire logic [sscpc_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [sscpc_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [sscpc_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  // AXI4-Lite read data
  output logic [sscpc_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // Pins from the analog side
  input  wire logic                          lineSyncPulse,
  input  wire logic                          firstLoopDetLock,
  input  wire logic                          secondLoopDetLock,
  // Control to the clock generator
  output logic                               firstLoopLocked,
  output logic                               secondLoopLocked,
  output logic                               maxModulationRate,
  output sscpc_pkg::sscpc_mode_t             pllMode,
  output logic [sscpc_pkg::MULT_W-1:0]       multiplyM,
  output logic [sscpc_pkg::MULT_W-1:0]       divideN,
  output logic                               fifoReset,
  output logic                               waveformReset,
  output logic                               modulatorLoad
);
  import sscpc_pkg::*;

  // Register index taken from a byte address
  function automatic logic [IDX_W-1:0] addrIndex(input logic [ADDR_W-1:0] a);
    return a[IDX_LSB +: IDX_W];
  endfunction

  // Stored value plus one, as the loop divider sees it
  function automatic logic [MULT_W-1:0] plusOne(input logic [REG_W-1:0] v);
    return {1'b0, v} + 9'h001;
  endfunction

  // True for any index up to the status register, whatever the current page
  function automatic logic isMapped(input logic [IDX_W-1:0] idx,
                                    input logic [PAGE_W-1:0] pg);
    logic hit;
    hit = 1'b0;
    if (idx == IDX_PAGE || idx == IDX_STATUS) begin
      hit = 1'b1;
    end else if (pg != PAGE_SPREAD) begin
      hit = (idx < IDX_PAGE);
    end else if (idx == IDX_SPREAD_CTRL2 || idx == IDX_MULT_M) begin
      hit = 1'b1;
    end else if (idx == IDX_DIV_N || idx == IDX_FIFO_HOLD) begin
      hit = 1'b1;
    end else begin
      hit = (idx < IDX_PAGE);
    end
    return hit;
  endfunction

  typedef struct packed {
    // Bus channel state
    logic                 awHeld;
    logic [IDX_W-1:0]     awIdx;
    logic                 wHeld;
    logic [REG_W-1:0]     wData;
    logic                 wLane;
    logic                 awReady;
    logic                 wReady;
    logic                 bValid;
    logic [1:0]           bResp;
    logic                 arReady;
    logic                 rValid;
    logic [DATA_W-1:0]    rData;
    logic [1:0]           rResp;
    // Registers
    logic [PAGE_W-1:0]    page;
    logic [REG_W-1:0]     ctrl2;
    logic [REG_W-1:0]     multRaw;
    logic [REG_W-1:0]     divRaw;
    logic [HOLD_W-1:0]    holdoff;
    // Derived outputs
    logic                 lock1;
    logic                 lock2;
    logic                 maxRate;
    sscpc_mode_t          mode;
    logic [MULT_W-1:0]    multOut;
    logic [MULT_W-1:0]    divOut;
    logic                 fifoRst;
    logic                 waveRst;
    logic                 smLoad;
    // Event tracking
    logic                 syncPrev;
    sscpc_mode_t          prevMode;
    logic                 holdTrig;
  } sscpc_top_t;

  sscpc_top_t st_ff;
  sscpc_top_t nxt_st;

  // Comes up with both loops off and unity ratios
  localparam sscpc_top_t TOP_RESET = '{
    awHeld: 1'b0,
    awIdx: '0,
    wHeld: 1'b0,
    wData: '0,
    wLane: 1'b0,
    awReady: 1'b0,
    wReady: 1'b0,
    bValid: 1'b0,
    bResp: RESP_OKAY,
    arReady: 1'b0,
    rValid: 1'b0,
    rData: '0,
    rResp: RESP_OKAY,
    page: PAGE_RESET,
    ctrl2: CTRL2_RESET,
    multRaw: MULT_RESET,
    divRaw: DIV_RESET,
    holdoff: HOLD_RESET,
    lock1: 1'b0,
    lock2: 1'b0,
    maxRate: 1'b0,
    mode: MODE_OFF,
    multOut: 9'h001,
    divOut: 9'h001,
    fifoRst: 1'b0,
    waveRst: 1'b0,
    smLoad: 1'b0,
    syncPrev: 1'b0,
    prevMode: MODE_OFF,
    holdTrig: 1'b0
  };

  // Synchronised pins: line sync, first and second lock detectors
  logic [2:0] pinRaw;
  logic [2:0] pinSync;

  assign pinRaw[PIN_LINE] = lineSyncPulse;
  assign pinRaw[PIN_DET1] = firstLoopDetLock;
  assign pinRaw[PIN_DET2] = secondLoopDetLock;

  sscpc_sync #(.W(3)) u_sync (
    .mclk    (mclk),
    .resetn  (resetn),
    .asyncIn (pinRaw),
    .syncOut (pinSync)
  );

  sscpc_hold_if hold ();

  sscpc_holdoff u_holdoff (
    .mclk   (mclk),
    .resetn (resetn),
    .hold   (hold)
  );

  // Count is latched at the trigger, so rewrites wait a line
  assign hold.trig  = st_ff.holdTrig;
  assign hold.count = st_ff.holdoff;

  logic            doWrite;
  logic            onSpread;
  logic            spreadStart;
  logic [IDX_W-1:0] arIdx;

  always_comb begin
    nxt_st      = st_ff;
    arIdx       = addrIndex(s_axi_araddr);
    onSpread    = (st_ff.page == PAGE_SPREAD);
    doWrite     = st_ff.awHeld && st_ff.wHeld && !st_ff.bValid;
    spreadStart = 1'b0;

    // Write address and data are taken independently, in either order
    if (s_axi_awvalid && st_ff.awReady) begin
      nxt_st.awHeld = 1'b1;
      nxt_st.awIdx  = addrIndex(s_axi_awaddr);
    end
    if (s_axi_wvalid && st_ff.wReady) begin
      nxt_st.wHeld = 1'b1;
      nxt_st.wData = s_axi_wdata[REG_W-1:0];
      nxt_st.wLane = s_axi_wstrb[0];
    end

    // Self-clearing strobes default low
    nxt_st.fifoRst  = 1'b0;
    nxt_st.waveRst  = 1'b0;
    nxt_st.smLoad   = 1'b0;
    nxt_st.holdTrig = 1'b0;

    if (doWrite) begin
      nxt_st.awHeld = 1'b0;
      nxt_st.wHeld  = 1'b0;
      nxt_st.bValid = 1'b1;
      nxt_st.bResp  = isMapped(st_ff.awIdx, st_ff.page) ? RESP_OKAY : RESP_SLVERR;
      if (st_ff.wLane) begin
        // page register answers on every page
        if (st_ff.awIdx == IDX_PAGE) begin
          nxt_st.page = st_ff.wData[PAGE_W-1:0];
        end else if (onSpread && st_ff.awIdx == IDX_SPREAD_CTRL2) begin
          nxt_st.ctrl2            = st_ff.wData;
          nxt_st.ctrl2[C2_LOAD_SM] = 1'b0;
          nxt_st.smLoad           = st_ff.wData[C2_LOAD_SM];
        end else if (onSpread && st_ff.awIdx == IDX_MULT_M) begin
          nxt_st.multRaw = st_ff.wData;
        end else if (onSpread && st_ff.awIdx == IDX_DIV_N) begin
          nxt_st.divRaw = st_ff.wData;
        end else if (onSpread && st_ff.awIdx == IDX_FIFO_HOLD) begin
          nxt_st.holdoff = st_ff.wData[FH_HOLD_HI:0];
          // one-cycle FIFO reset, bit never stored
          nxt_st.fifoRst = st_ff.wData[FH_FIFO_RST];
        end
      end
    end
    if (st_ff.bValid && s_axi_bready) begin
      nxt_st.bValid = 1'b0;
    end
    // Readies stay low until the response is taken
    nxt_st.awReady = !nxt_st.awHeld && !nxt_st.bValid;
    nxt_st.wReady  = !nxt_st.wHeld && !nxt_st.bValid;

    // Read channel: one outstanding read, answered the cycle after it is taken
    if (s_axi_arvalid && st_ff.arReady) begin
      nxt_st.rValid = 1'b1;
      nxt_st.rResp  = isMapped(arIdx, st_ff.page) ? RESP_OKAY : RESP_SLVERR;
      nxt_st.rData  = '0;
      if (arIdx == IDX_PAGE) begin
        nxt_st.rData[PAGE_W-1:0] = st_ff.page;
      end else if (arIdx == IDX_STATUS) begin
        nxt_st.rData[ST_FIRST_MULTIPLIER_LOOP_LOCK] = st_ff.lock1;
        nxt_st.rData[ST_SECOND_MULTIPLIER_LOOP_LOCK] = st_ff.lock2;
        nxt_st.rData[ST_HOLD_BUSY] = hold.busy;
        nxt_st.rData[ST_SPREAD_ON] = (st_ff.mode != MODE_OFF);
      end else if (onSpread && arIdx == IDX_SPREAD_CTRL2) begin
        nxt_st.rData[REG_W-1:0] = st_ff.ctrl2;
      end else if (onSpread && arIdx == IDX_MULT_M) begin
        nxt_st.rData[REG_W-1:0] = st_ff.multRaw;
      end else if (onSpread && arIdx == IDX_DIV_N) begin
        nxt_st.rData[REG_W-1:0] = st_ff.divRaw;
      end else if (onSpread && arIdx == IDX_FIFO_HOLD) begin
        // Reset bit self-clears, so it always reads back as zero
        nxt_st.rData[FH_HOLD_HI:0] = st_ff.holdoff;
      end
    end
    if (st_ff.rValid && s_axi_rready) begin
      nxt_st.rValid = 1'b0;
    end
    // No new read is taken while an answer waits
    nxt_st.arReady = !nxt_st.rValid;

    // second loop lock forced by override
    nxt_st.lock2 = pinSync[PIN_DET2] || st_ff.ctrl2[C2_OVR_SECOND_MULTIPLIER_LOOP];
    // first loop lock forced by override
    nxt_st.lock1 = pinSync[PIN_DET1] || st_ff.ctrl2[C2_OVR_FIRST_MULTIPLIER_LOOP];
    nxt_st.maxRate = st_ff.ctrl2[C2_MAX_RATE];
    // mode field passed straight to the clock generator
    nxt_st.mode = sscpc_mode_t'(st_ff.ctrl2[C2_MODE_HI:C2_MODE_LO]);
    nxt_st.multOut = plusOne(st_ff.multRaw);
    nxt_st.divOut = plusOne(st_ff.divRaw);

    // leaving the disabled mode starts spreading
    nxt_st.prevMode = st_ff.mode;
    spreadStart     = (st_ff.prevMode == MODE_OFF) && (st_ff.mode != MODE_OFF);
    if (spreadStart) begin
      nxt_st.fifoRst = 1'b1;
      nxt_st.smLoad  = 1'b1;
    end

    // rising line sync starts the holdoff
    nxt_st.syncPrev = pinSync[PIN_LINE];
    nxt_st.holdTrig = pinSync[PIN_LINE] && !st_ff.syncPrev;

    // Enables are sampled when the holdoff expires, not at the line sync
    if (hold.fire) begin
      // FIFO reset on line sync when enabled
      if (st_ff.ctrl2[C2_FIFO_LS]) begin
        nxt_st.fifoRst = 1'b1;
      end
      // waveform restart on line sync when enabled
      if (st_ff.ctrl2[C2_WAVE_LS]) begin
        nxt_st.waveRst = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= TOP_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Bus outputs
  assign s_axi_awready = st_ff.awReady;
  assign s_axi_wready  = st_ff.wReady;
  assign s_axi_bvalid  = st_ff.bValid;
  assign s_axi_bresp   = st_ff.bResp;
  assign s_axi_arready = st_ff.arReady;
  assign s_axi_rvalid  = st_ff.rValid;
  assign s_axi_rdata   = st_ff.rData;
  assign s_axi_rresp   = st_ff.rResp;

  // Clock generator outputs
  assign firstLoopLocked   = st_ff.lock1;
  assign secondLoopLocked  = st_ff.lock2;
  assign maxModulationRate = st_ff.maxRate;
  assign pllMode           = st_ff.mode;
  assign multiplyM         = st_ff.multOut;
  assign divideN           = st_ff.divOut;
  assign fifoReset         = st_ff.fifoRst;
  assign waveformReset     = st_ff.waveRst;
  assign modulatorLoad     = st_ff.smLoad;
endmodule

// ===== testbench/sscpc_monitor.sv
// Port-level assertions for the spread clock PLL control block
module sscpc_monitor (
  // Clock and reset
  input wire logic                         mclk,
  input wire logic                         resetn,
  // Bus responses
  input wire logic                         s_axi_bvalid,
  input wire logic                         s_axi_bready,
  input wire logic                         s_axi_rvalid,
  input wire logic                         s_axi_rready,
  input wire logic [sscpc_pkg::DATA_W-1:0] s_axi_rdata,
  // Clock generator side
  input wire logic                         firstLoopDetLock,
  input wire logic                         secondLoopDetLock,
  input wire logic                         firstLoopLocked,
  input wire logic                         secondLoopLocked,
  input wire sscpc_pkg::sscpc_mode_t       pllMode,
  input wire logic [sscpc_pkg::MULT_W-1:0] multiplyM,
  input wire logic [sscpc_pkg::MULT_W-1:0] divideN,
  input wire logic                         fifoReset,
  input wire logic                         waveformReset,
  input wire logic                         modulatorLoad
);
  timeunit 1ns;
  timeprecision 1ps;
  import sscpc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Two sync flops plus the output register: four high samples must show lock
  sequence s_det1_held; firstLoopDetLock [*4]; endsequence
  sequence s_det2_held; secondLoopDetLock [*4]; endsequence
  sequence s_leave_off; $past(pllMode) == MODE_OFF && pllMode != MODE_OFF; endsequence
  a_mode_reset: assert property (!$past(resetn) |-> pllMode == MODE_OFF)
    else $error("mode not off after reset");
  a_lock_first: assert property (s_det1_held |-> firstLoopLocked)
    else $error("first loop lock missing");
  a_lock_second: assert property (s_det2_held |-> secondLoopLocked)
    else $error("second loop lock missing");
  a_mult_range: assert property (multiplyM inside {[9'h001:9'h100]})
    else $error("multiplier out of range");
  a_div_range: assert property (divideN inside {[9'h001:9'h100]})
    else $error("divider out of range");
  a_fifo_pulse: assert property (fifoReset |=> !fifoReset)
    else $error("fifo reset too long");
  a_wave_pulse: assert property (waveformReset |=> !waveformReset)
    else $error("waveform reset too long");
  a_load_pulse: assert property (modulatorLoad |=> !modulatorLoad)
    else $error("modulator load too long");
  a_spread_start: assert property (s_leave_off |=> fifoReset && modulatorLoad)
    else $error("no reset at spread start");
  a_write_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("second write response");
  a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("second read response");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
endmodule

bind sscpc_top sscpc_monitor i_mon (
  .mclk(mclk), .resetn(resetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .firstLoopDetLock(firstLoopDetLock), .secondLoopDetLock(secondLoopDetLock),
  .firstLoopLocked(firstLoopLocked), .secondLoopLocked(secondLoopLocked),
  .pllMode(pllMode), .multiplyM(multiplyM), .divideN(divideN), .fifoReset(fifoReset),
  .waveformReset(waveformReset), .modulatorLoad(modulatorLoad)
);

// ===== testbench/sscpc_clock_source.sv
// Far-side model: loop lock detectors and the line sync pin
module sscpc_clock_source (
  // Clock
  input  wire logic mclk,
  // Pins toward the block
  output logic      lineSyncPulse,
  output logic      firstLoopDetLock,
  output logic      secondLoopDetLock
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    lineSyncPulse = 1'b0;
    firstLoopDetLock = 1'b0;
    secondLoopDetLock = 1'b0;
  end
  // Called just after an edge, so the levels move off the sampling edge
  task automatic set_det(input logic d1, input logic d2);
    firstLoopDetLock <= d1;
    secondLoopDetLock <= d2;
  endtask
  // Three cycles wide so the two-flop synchroniser cannot miss it
  task automatic sync_pulse();
    @(posedge mclk);
    lineSyncPulse <= 1'b1;
    repeat (3) @(posedge mclk);
    lineSyncPulse <= 1'b0;
  endtask
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the spread clock PLL control block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sscpc_pkg::*;
  logic        mclk = 1'b0, resetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, v;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hf, r4;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, lineSync, det1, det2;
  logic        lock1, lock2, maxRate, fifoRst, waveRst, modLoad, lane0 = 1'b1;
  logic [1:0]  bresp, rresp;
  logic [8:0]  multM, divN;
  sscpc_mode_t mode;
  logic [1:0]  codes [3] = '{2'b11, 2'b01, 2'b00};
  logic [7:0]  ens [3] = '{8'h22, 8'h42, 8'h02};
  int          err_count = 0, check_count = 0, cycCount = 0, base, lat, h, f0, w0, l0;
  int          fifoCnt = 0, waveCnt = 0, loadCnt = 0, fifoCyc = 0, waveCyc = 0;
  integer      seed = 32'h04d650ed;

  always #5 mclk = ~mclk;

  sscpc_top i_dut (
    .mclk(mclk), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .lineSyncPulse(lineSync), .firstLoopDetLock(det1), .secondLoopDetLock(det2),
    .firstLoopLocked(lock1), .secondLoopLocked(lock2), .maxModulationRate(maxRate),
    .pllMode(mode), .multiplyM(multM), .divideN(divN), .fifoReset(fifoRst),
    .waveformReset(waveRst), .modulatorLoad(modLoad)
  );
  sscpc_clock_source i_src (
    .mclk(mclk), .lineSyncPulse(lineSync), .firstLoopDetLock(det1), .secondLoopDetLock(det2)
  );

  // Pulse counters, with the cycle of the last FIFO and waveform pulse, for latency deltas
  always @(posedge mclk) begin
    cycCount <= cycCount + 1;
    if (fifoRst === 1'b1) begin
      fifoCnt <= fifoCnt + 1;
      fifoCyc <= cycCount;
    end
    if (waveRst === 1'b1) begin
      waveCnt <= waveCnt + 1;
      waveCyc <= cycCount;
    end
    if (modLoad === 1'b1) loadCnt <= loadCnt + 1;
    if (cycCount == 20000) begin
      err_count = err_count + 1;
      finish_test();
    end
  end

  function automatic logic [8:0] exp_ratio(input logic [7:0] b);
    return {1'b0, b} + 9'h001;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      err_count = err_count + 1;
    end
  endtask

  // Each task starts on a fresh edge so no signal is assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'($random(seed)), d};
    wstrb <= {3'($random(seed)), lane0};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 64);
    bready <= 1'b0;
    check(32'(bresp), 32'(er));
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 64);
    rready <= 1'b0;
    check(rdata, ed);
    check(32'(rresp), 32'(er));
  endtask

  task automatic measure(input int hv, output int l);
    int n;
    wr(8'h78, 8'(hv), RESP_OKAY);
    f0 = fifoCnt;
    l = cycCount;
    i_src.sync_pulse();
    n = 0;
    while (fifoCnt == f0 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    l = fifoCyc - l;
  endtask

  task automatic finish_test();
    $display("Checks %0d, errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    check(32'(mode), 32'(MODE_OFF));
    check(32'(multM), 32'h1);
    check(32'(divN), 32'h1);
    rd_chk(8'h7c, 32'h0, RESP_OKAY);
    rd_chk(8'h6c, 32'h0, RESP_OKAY);
    wr(8'h70, 8'h55, RESP_OKAY);
    wr(8'h7c, 8'h02, RESP_OKAY);
    rd_chk(8'h7c, 32'h2, RESP_OKAY);
    rd_chk(8'h70, 32'h0, RESP_OKAY);
    rd_chk(8'h6c, 32'h2, RESP_OKAY);
    rd_chk(8'h74, 32'h0, RESP_OKAY);
    rd_chk(8'h78, 32'h0, RESP_OKAY);
    rd_chk(8'h84, 32'h0, RESP_SLVERR);
    wr(8'h84, 8'hff, RESP_SLVERR);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
      wr(8'h70, v, RESP_OKAY);
      wr(8'h74, ~v, RESP_OKAY);
      @(posedge mclk);
      check(32'(multM), 32'(exp_ratio(v)));
      check(32'(divN), 32'(exp_ratio(~v)));
      rd_chk(8'h74, {24'h0, ~v}, RESP_OKAY);
    end
    // Lane 0 strobe low: the write is acknowledged but changes nothing
    lane0 = 1'b0;
    wr(8'h70, ~v, RESP_OKAY);
    lane0 = 1'b1;
    rd_chk(8'h70, {24'h0, v}, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      r4 = (i == 0) ? 4'b1100 : 4'($random(seed));
      i_src.set_det(r4[0], r4[1]);
      wr(8'h6c, {3'b000, r4[3], r4[2], r4[0] ^ r4[3], 2'b10}, RESP_OKAY);
      repeat (4) @(posedge mclk);
      check(32'(lock1), 32'(r4[0] | r4[2]));
      check(32'(lock2), 32'(r4[1] | r4[3]));
      check(32'(maxRate), 32'(r4[0] ^ r4[3]));
    end
    foreach (codes[i]) begin
      l0 = loadCnt;
      f0 = fifoCnt;
      wr(8'h6c, {6'h00, codes[i]}, RESP_OKAY);
      repeat (3) @(posedge mclk);
      check(32'(mode), 32'(codes[i]));
      check(32'(loadCnt - l0), 32'h1);
      check(32'(fifoCnt - f0), 32'h1);
      wr(8'h6c, 8'h02, RESP_OKAY);
    end
    l0 = loadCnt;
    wr(8'h6c, 8'h82, RESP_OKAY);
    rd_chk(8'h6c, 32'h2, RESP_OKAY);
    check(32'(loadCnt - l0), 32'h1);
    f0 = fifoCnt;
    wr(8'h78, 8'h80, RESP_OKAY);
    rd_chk(8'h78, 32'h0, RESP_OKAY);
    check(32'(fifoCnt - f0), 32'h1);
    wr(8'h6c, 8'h62, RESP_OKAY);
    measure(0, base);
    for (int i = 0; i < 5; i++) begin
      h = (i == 0) ? 127 : (i == 1) ? 1 : ($random(seed) & 127);
      measure(h, lat);
      check(32'(lat - base), 32'(h));
      check(32'(waveCyc), 32'(fifoCyc));
    end
    foreach (ens[i]) begin
      wr(8'h6c, ens[i], RESP_OKAY);
      f0 = fifoCnt;
      w0 = waveCnt;
      i_src.sync_pulse();
      repeat (140) @(posedge mclk);
      check(32'(fifoCnt - f0), 32'(ens[i][6]));
      check(32'(waveCnt - w0), 32'(ens[i][5]));
    end
    finish_test();
  end
endmodule
